// ==== logic/agsq_pkg.sv ====
package agsq_pkg;
   // Clock and the scheduling tick that paces auto conversions.
   localparam int unsigned CLK_HZ   = 10_000_000;
   localparam int unsigned TICK_US  = 1000;
   localparam int unsigned TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
   localparam int unsigned NSLOT    = 2;

   // Register byte offsets.
   localparam logic [7:0] OFS_SOFT_SEL = 8'h00;
   localparam logic [7:0] OFS_CTRL1    = 8'h04;
   localparam logic [7:0] OFS_MASK     = 8'h08;
   localparam logic [7:0] OFS_STAT     = 8'h0c;
   localparam logic [7:0] OFS_SRES_H   = 8'h10;
   localparam logic [7:0] OFS_SRES_L   = 8'h14;
   localparam logic [7:0] OFS_ASEL     = 8'h18;
   localparam logic [7:0] OFS_ACTL     = 8'h1c;
   localparam logic [7:0] OFS_SLOT0    = 8'h20;
   localparam logic [7:0] SLOT_STRIDE  = 8'h10;
   localparam logic [7:0] OFS_THR_H    = 8'h00;
   localparam logic [7:0] OFS_THR_L    = 8'h04;
   localparam logic [7:0] OFS_ARES_H   = 8'h08;
   localparam logic [7:0] OFS_ARES_L   = 8'h0c;
   localparam logic [7:0] OFS_SODLY    = 8'h40;

   // Field positions.
   localparam int SSEL_EN     = 0;
   localparam int SSEL_START  = 1;
   localparam int SSEL_CH     = 4;
   localparam int CTL1_FORCE  = 0;
   localparam int CTL1_ISRC   = 1;
   localparam int INT_EOC     = 0;
   localparam int INT_SLOT    = 1;
   localparam int ACTL_IVL    = 0;
   localparam int ACTL_EN     = 4;
   localparam int ACTL_SD     = 6;
   localparam int THR_POL     = 7;
   localparam int ASEL_STRIDE = 4;

   // Reset values.
   localparam logic [2:0] MASK_RST = 3'h7;

   typedef logic [2:0]  agsq_chan_t;
   typedef logic [11:0] agsq_code_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } agsq_fsm_e;

   // Request toward the analog converter.
   typedef struct packed {
      logic       pwr;
      logic       start;
      agsq_chan_t chan;
      logic [1:0] isrc;
   } agsq_adc_req_s;

   // Answer from the analog converter.
   typedef struct packed {
      logic       done;
      agsq_code_t data;
   } agsq_adc_rsp_s;
endpackage

// ==== logic/agsq_seq.sv ====
// Contract
// R1: Software enables soft conversions before asking for one.
// R2: Channel zero conversions carry the configured current source setting.
// R3: Converter powers only during conversions unless force-on is set.
// R4: Soft end-of-conversion interrupt reaches host only when unmasked.
// R5: Finished soft conversion sets the soft end-of-conversion flag.
// R6: Result is 12 bits, upper four in high, lower eight in low.
// R7: Auto slots convert repeatedly at the programmed interval.
// R8: Each auto result is compared with a 12-bit split threshold.
// R9: Polarity bit chooses above-threshold or below-threshold events.
// R10: Per-slot shutdown enable lets a threshold event request switch-off.
// R11: Enabled slot threshold crossing sets its slot flag.
// R12: Auto results sit in their own high and low register pair.
// R13: Shutdown follows the switch-off delay unless the flag is cleared.
// R14: Second slot is independent and works like the first.
// R15: Start bit is one-shot, cleared when the conversion is accepted.
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/100ps
module agsq_seq
   import agsq_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output agsq_adc_req_s    adc_req,
   input  wire agsq_adc_rsp_s adc_rsp,
   output logic             irq,
   output logic             shutdown_req
);
   typedef struct packed {
      agsq_fsm_e                    st;
      logic [1:0]                   own;
      logic                         sw_en, sw_start;
      agsq_chan_t                   sw_ch;
      logic                         force_on;
      logic [1:0]                   isrc;
      logic [2:0]                   mask;
      logic [2:0]                   stat;
      agsq_code_t                   sw_res;
      logic [3:0]                   ivl;
      logic [NSLOT-1:0]             aen, sden;
      agsq_chan_t [NSLOT-1:0]       ach;
      agsq_code_t [NSLOT-1:0]       thr;
      logic [NSLOT-1:0]             pol;
      agsq_code_t [NSLOT-1:0]       ares;
      logic [7:0]                   sodly, socnt;
      logic                         shut, irq, wreq;
      logic [31:0]                  rdata;
      agsq_adc_req_s                adc;
   } agsq_main_s;

   localparam agsq_main_s RST_S = '{
      st: ST_IDLE, mask: MASK_RST, wreq: 1'b1, default: '0};

   agsq_main_s       s_q;
   agsq_main_s       s_d;
   logic             tick, acc, pend, go;
   logic [1:0]       own;
   agsq_chan_t       ch;
   logic [2:0]       clr, set;
   logic [31:0]      rd, wd;
   logic [NSLOT-1:0] gnt, due, hit, sdone;

   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("agsq_seq: TICK_CYCLES must be at least 2");
   end

   // Byte address of a register inside an auto slot's block.
   function automatic logic [7:0] slot_ofs(input int i,
                                           input logic [7:0] sub);
      slot_ofs = 8'(OFS_SLOT0 + SLOT_STRIDE * i + sub);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Scheduling tick and the two auto slots.
   agsq_tick #(.CYC (TICK_CYCLES)) u_tick (
      .clk    (clk),
      .resetn (resetn),
      .tick   (tick)
   );

   for (genvar i = 0; i < NSLOT; i++) begin : g_slot
      // Completion is routed to the slot that owns the conversion.
      assign sdone[i] = (s_q.st == ST_BUSY) && adc_rsp.done
                        && (s_q.own == 2'(i + 1));
      agsq_slot u_slot ( // R14
         .clk    (clk),
         .resetn (resetn),
         .tick   (tick),
         .en     (s_q.aen[i]),
         .ivl    (s_q.ivl),
         .grant  (gnt[i]),
         .done   (sdone[i]),
         .res    (adc_rsp.data),
         .thr    (s_q.thr[i]),
         .pol    (s_q.pol[i]),
         .due    (due[i]),
         .hit    (hit[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state: sequencer, register writes, flags and bus answer.
   always_comb begin
      s_d  = s_q;
      wd   = avs_writedata;
      acc  = avs_write && !s_q.wreq;
      gnt  = '0;
      set  = '0;
      clr  = '0;
      go   = 1'b0;
      own  = 2'h0;
      ch   = s_q.sw_ch;
      rd   = 32'h0;
      s_d.adc.start = 1'b0;

      // Soft requests win over auto slots; slot a wins over slot b.
      case (s_q.st)
         ST_IDLE: begin
            if (s_q.sw_start && s_q.sw_en) begin // R1
               go = 1'b1;
               s_d.sw_start = 1'b0; // R15
            end else if (due[0]) begin
               go     = 1'b1;
               own    = 2'h1;
               ch     = s_q.ach[0];
               gnt[0] = 1'b1;
            end else if (due[1]) begin
               go     = 1'b1;
               own    = 2'h2;
               ch     = s_q.ach[1];
               gnt[1] = 1'b1;
            end
            if (go) begin
               s_d.st        = ST_BUSY;
               s_d.own       = own;
               s_d.adc.start = 1'b1;
               s_d.adc.chan  = ch;
               s_d.adc.isrc  = (ch == 3'h0) ? s_q.isrc : 2'h0; // R2
            end
         end
         ST_BUSY: begin
            if (adc_rsp.done) begin
               s_d.st = ST_IDLE;
               if (s_q.own == 2'h0) begin
                  s_d.sw_res   = adc_rsp.data; // R6
                  set[INT_EOC] = 1'b1; // R5
               end
               for (int i = 0; i < NSLOT; i++) begin
                  if (sdone[i]) begin
                     s_d.ares[i] = adc_rsp.data; // R12
                     if (hit[i]) set[INT_SLOT + i] = 1'b1; // R11
                  end
               end
            end
         end
         default: s_d.st = ST_IDLE;
      endcase

      // Writes take effect on the edge where waitrequest is seen low.
      if (acc) begin
         case (avs_address)
            OFS_SOFT_SEL: begin
               s_d.sw_en = wd[SSEL_EN];
               s_d.sw_ch = wd[SSEL_CH +: 3];
               if (wd[SSEL_START]) s_d.sw_start = 1'b1; // R15
            end
            OFS_CTRL1: begin
               s_d.force_on = wd[CTL1_FORCE];
               s_d.isrc     = wd[CTL1_ISRC +: 2];
            end
            OFS_MASK:  s_d.mask  = wd[2:0];
            OFS_STAT:  clr       = wd[2:0];
            OFS_ASEL: begin
               s_d.ach[0] = wd[2:0];
               s_d.ach[1] = wd[ASEL_STRIDE +: 3];
            end
            OFS_ACTL: begin
               s_d.ivl  = wd[ACTL_IVL +: 4];
               s_d.aen  = wd[ACTL_EN +: NSLOT];
               s_d.sden = wd[ACTL_SD +: NSLOT]; // R10
            end
            OFS_SODLY: s_d.sodly = wd[7:0];
            default: ;
         endcase
         for (int i = 0; i < NSLOT; i++) begin
            if (avs_address == slot_ofs(i, OFS_THR_H)) begin
               s_d.pol[i]        = wd[THR_POL]; // R9
               s_d.thr[i][11:8]  = wd[3:0]; // R8
            end
            if (avs_address == slot_ofs(i, OFS_THR_L))
               s_d.thr[i][7:0] = wd[7:0]; // R8
         end
      end
      // Hardware set wins over a software clear in the same cycle.
      s_d.stat = (s_q.stat & ~clr) | set;
      // Switch-off timer runs while an enabled slot flag stays set.
      pend = |(s_q.stat[INT_SLOT +: NSLOT] & s_q.sden); // R10
      if (!pend) begin
         s_d.socnt = 8'h00; // R13
      end else if (s_q.socnt == s_q.sodly) begin
         s_d.shut = 1'b1; // R13
      end else if (tick) begin
         s_d.socnt = s_q.socnt + 8'h01;
      end
      s_d.adc.pwr = s_d.force_on || (s_d.st == ST_BUSY); // R3
      s_d.irq     = |(s_d.stat & ~s_d.mask); // R4

      // Read mux; unmapped addresses read as zero.
      case (avs_address)
         OFS_SOFT_SEL: begin
            rd[SSEL_EN]       = s_q.sw_en;
            rd[SSEL_START]    = s_q.sw_start;
            rd[SSEL_CH +: 3]  = s_q.sw_ch;
         end
         OFS_CTRL1: begin
            rd[CTL1_FORCE]    = s_q.force_on;
            rd[CTL1_ISRC +: 2] = s_q.isrc;
         end
         OFS_MASK:   rd[2:0] = s_q.mask;
         OFS_STAT:   rd[2:0] = s_q.stat;
         OFS_SRES_H: rd[3:0] = s_q.sw_res[11:8]; // R6
         OFS_SRES_L: rd[7:0] = s_q.sw_res[7:0]; // R6
         OFS_ASEL: begin
            rd[2:0]             = s_q.ach[0];
            rd[ASEL_STRIDE +: 3] = s_q.ach[1];
         end
         OFS_ACTL: begin
            rd[ACTL_IVL +: 4]  = s_q.ivl;
            rd[ACTL_EN +: NSLOT] = s_q.aen;
            rd[ACTL_SD +: NSLOT] = s_q.sden;
         end
         OFS_SODLY:  rd[7:0] = s_q.sodly;
         default: ;
      endcase
      for (int i = 0; i < NSLOT; i++) begin
         if (avs_address == slot_ofs(i, OFS_THR_H)) begin
            rd[THR_POL] = s_q.pol[i];
            rd[3:0]     = s_q.thr[i][11:8];
         end
         if (avs_address == slot_ofs(i, OFS_THR_L))
            rd[7:0] = s_q.thr[i][7:0];
         if (avs_address == slot_ofs(i, OFS_ARES_H))
            rd[3:0] = s_q.ares[i][11:8]; // R12
         if (avs_address == slot_ofs(i, OFS_ARES_L))
            rd[7:0] = s_q.ares[i][7:0]; // R12
      end

      // One wait state per access keeps decode off the bus path.
      s_d.wreq = !((avs_read || avs_write) && s_q.wreq);
      if (avs_read && s_q.wreq) s_d.rdata = rd;
   end

   // State register.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= RST_S;
      end else begin
         s_q <= s_d;
      end
   end
   // Every output is a field of the state register.
   assign avs_readdata    = s_q.rdata;
   assign avs_waitrequest = s_q.wreq;
   assign adc_req         = s_q.adc;
   assign irq             = s_q.irq;
   assign shutdown_req    = s_q.shut;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // The request was built from the setting of the cycle before it.
   property p_isrc;
      adc_req.start |-> (adc_req.chan == 3'h0)
         ? (adc_req.isrc == $past(s_q.isrc)) : (adc_req.isrc == 2'h0);
   endproperty
   a_isrc: assert property (p_isrc) // R2
      else $error("current source wrong for channel");
   property p_pwr;
      adc_req.pwr == (s_q.force_on || (s_q.st == ST_BUSY));
   endproperty
   a_pwr: assert property (p_pwr) // R3
      else $error("converter power does not follow demand");
   property p_irq;
      irq == |(s_q.stat & ~s_q.mask);
   endproperty
   a_irq: assert property (p_irq) // R4
      else $error("interrupt output disagrees with status and mask");
   property p_eoc;
      (s_q.st == ST_BUSY && adc_rsp.done && s_q.own == 2'h0)
         |=> s_q.stat[INT_EOC] && (s_q.sw_res == $past(adc_rsp.data));
   endproperty
   a_eoc: assert property (p_eoc) // R5 R6
      else $error("soft conversion end not recorded");
   property p_slot_a;
      (sdone[0] && s_q.aen[0] && (s_q.pol[0]
         ? adc_rsp.data > s_q.thr[0] : adc_rsp.data < s_q.thr[0]))
         |=> s_q.stat[INT_SLOT] && s_q.ares[0] == $past(adc_rsp.data);
   endproperty
   a_slot_a: assert property (p_slot_a) // R8 R9 R11 R12
      else $error("slot a threshold event missed");
   property p_slot_b;
      (sdone[1] && s_q.aen[1] && (s_q.pol[1]
         ? adc_rsp.data > s_q.thr[1] : adc_rsp.data < s_q.thr[1]))
         |=> s_q.stat[INT_SLOT + 1];
   endproperty
   a_slot_b: assert property (p_slot_b) // R14
      else $error("slot b threshold event missed");
   property p_shut;
      (pend && s_q.socnt == s_q.sodly) |=> shutdown_req;
   endproperty
   a_shut: assert property (p_shut) // R10 R13
      else $error("shutdown not raised after delay");
   property p_noshut;
      (!pend && !shutdown_req) |=> !shutdown_req;
   endproperty
   a_noshut: assert property (p_noshut) // R13
      else $error("shutdown raised without pending flag");
   property p_oneshot;
      (s_q.st == ST_IDLE && s_q.sw_start && s_q.sw_en)
         |=> adc_req.start && s_q.own == 2'h0 && s_q.st == ST_BUSY;
   endproperty
   a_oneshot: assert property (p_oneshot) // R15
      else $error("soft start not accepted");
   c_soft: cover property (s_q.st == ST_BUSY && adc_rsp.done
                           && s_q.own == 2'h0);
   c_hit_a: cover property (sdone[0] && hit[0]);
   c_hit_b: cover property (sdone[1] && hit[1]);
   c_shut: cover property ($rose(shutdown_req));
endmodule // agsq_seq

// ==== logic/agsq_slot.sv ====
`timescale 1ns/100ps
module agsq_slot
   import agsq_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       tick,
   input  wire logic       en,
   input  wire logic [3:0] ivl,
   input  wire logic       grant,
   input  wire logic       done,
   input  wire agsq_code_t res,
   input  wire agsq_code_t thr,
   input  wire logic       pol,
   output logic            due,
   output logic            hit
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       due;
   } agsq_slot_s;

   agsq_slot_s s_q;
   agsq_slot_s s_d;

   // Interval counter: a request is raised every ivl+1 ticks.
   always_comb begin
      s_d = s_q;
      if (!en) begin
         s_d = '0;
      end else begin
         if (grant) begin
            s_d.due = 1'b0;
         end
         if (tick) begin
            if (s_q.cnt == ivl) begin // R7
               s_d.cnt = 4'h0;
               s_d.due = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt + 4'h1;
            end
         end
      end
   end

   // State register.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign due = s_q.due;
   // Polarity one fires above the threshold, zero below it.
   assign hit = done && en && (pol ? (res > thr) : (res < thr)); // R8 R9

   property p_interval;
      @(posedge clk) disable iff (!resetn)
      $rose(due) |-> $past(tick) && ($past(s_q.cnt) == $past(ivl));
   endproperty
   a_interval: assert property (p_interval) // R7
      else $error("slot request raised off its interval");
endmodule // agsq_slot

// ==== logic/agsq_tick.sv ====
`timescale 1ns/100ps
module agsq_tick
   import agsq_pkg::*;
#(
   parameter int unsigned CYC = TICK_CYC
) (
   input  wire logic clk,
   input  wire logic resetn,
   output logic      tick
);
   localparam int unsigned CW = $clog2(CYC);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } agsq_tick_s;

   agsq_tick_s s_q;
   agsq_tick_s s_d;

   if (CYC < 2) begin : g_bad_cyc
      $error("agsq_tick: CYC must be at least 2");
   end

   // Free running divider; one pulse per CYC clocks.
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == CW'(CYC - 1)) begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + CW'(1);
      end
   end

   // State register.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule // agsq_tick

// ==== verif/agsq_tb.sv ====
`timescale 1ns/100ps
module testbench
   import agsq_pkg::*;
;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
   } agsq_tb_row_s;

   logic          clk;
   logic          resetn;
   logic [7:0]    avs_address;
   logic          avs_read;
   logic          avs_write;
   logic [31:0]   avs_writedata;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   agsq_adc_req_s adc_req;
   agsq_adc_rsp_s adc_rsp = '0;
   agsq_adc_req_s seen = '0;
   logic          irq;
   logic          shutdown_req;
   logic [31:0]   rd;
   agsq_code_t    conv_val [8];
   int            fail_count;
   int            samples_checked;
   int            starts = 0;
   int            cd = 0;
   int            s0;

   // Reads are checked against the written value; reset and unmapped rows too.
   agsq_tb_row_s rows [16] = '{
      '{1'b0, 8'h08, 32'h7}, '{1'b0, 8'h0c, 32'h0}, '{1'b0, 8'h00, 32'h0},
      '{1'b0, 8'h1c, 32'h0}, '{1'b0, 8'h2c, 32'h0}, '{1'b0, 8'h80, 32'h0},
      '{1'b1, 8'h18, 32'h52}, '{1'b0, 8'h18, 32'h52},
      '{1'b1, 8'h80, 32'hff}, '{1'b0, 8'h80, 32'h0},
      '{1'b1, 8'h24, 32'hab}, '{1'b0, 8'h24, 32'hab},
      '{1'b1, 8'h04, 32'h4}, '{1'b0, 8'h04, 32'h4},
      '{1'b1, 8'h40, 32'h8}, '{1'b0, 8'h40, 32'h8}};

   agsq_seq #(
      .TICK_CYCLES (4)
   ) agsq_seq_inst (
      .clk             (clk),
      .resetn          (resetn),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .adc_req         (adc_req),
      .adc_rsp         (adc_rsp),
      .irq             (irq),
      .shutdown_req    (shutdown_req)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock at 10 MHz.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Converter stand-in: answers each start three cycles later.
   always @(posedge clk) begin
      adc_rsp.done <= 1'b0;
      if (cd == 1) begin
         adc_rsp.done <= 1'b1;
         adc_rsp.data <= conv_val[seen.chan];
      end
      if (cd > 0) begin
         cd <= cd - 1;
      end
      if (adc_req.start === 1'b1) begin
         seen   <= adc_req;
         starts <= starts + 1;
         cd     <= 3;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One bus access; the request stands until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n >= 100) begin
         check(32'h0, 32'h1);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask

   // Polls status until a bit shows; bounded so a dead slot cannot hang.
   task automatic poll(input logic [31:0] m);
      int n;
      n = 0;
      do begin
         bus(1'b0, 8'h0c, 32'h0);
         n++;
      end while ((rd & m) == 32'h0 && n < 100);
      check(rd & m, m);
   endtask

   task automatic summarize;
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Watchdog sized well above the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, 0, 1);
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      fail_count = 0;
      samples_checked = 0;
      conv_val = '{12'h000, 12'h000, 12'h800, 12'h222,
                   12'h000, 12'h100, 12'h000, 12'h000};
      conv_val[0] = 12'h5a3;
      repeat (8) @(posedge clk);
      check({avs_waitrequest, irq, shutdown_req, adc_req}, {1'b1, 9'h0});
      resetn <= 1'b1;
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) check(rd, rows[i].d);
      end
      $display("Test registers done");

      // Start without enable must wait; then a channel-zero conversion.
      s0 = starts;
      bus(1'b1, 8'h00, 32'h02);
      repeat (10) @(posedge clk);
      check(starts - s0, 0);
      check(adc_req.pwr, 1'b0);
      rdchk(8'h00, 32'h02);
      bus(1'b1, 8'h00, 32'h03);
      repeat (10) @(posedge clk);
      check(starts - s0, 1);
      check({seen.pwr, seen.chan, seen.isrc}, {1'b1, 3'h0, 2'h2});
      check({adc_req.pwr, irq}, 2'b00);
      rdchk(8'h0c, 32'h1);
      rdchk(8'h10, 32'h5);
      rdchk(8'h14, 32'ha3);
      rdchk(8'h00, 32'h01);
      bus(1'b1, 8'h08, 32'h6);
      repeat (2) @(posedge clk);
      check(irq, 1'b1);
      bus(1'b1, 8'h0c, 32'h1);
      repeat (2) @(posedge clk);
      check(irq, 1'b0);
      bus(1'b1, 8'h00, 32'h33);
      repeat (10) @(posedge clk);
      check({seen.chan, seen.isrc}, {3'h3, 2'h0});
      rdchk(8'h14, 32'h22);
      bus(1'b1, 8'h04, 32'h05);
      repeat (3) @(posedge clk);
      check(adc_req.pwr, 1'b1);
      bus(1'b1, 8'h04, 32'h04);
      bus(1'b1, 8'h00, 32'h00);
      bus(1'b1, 8'h0c, 32'h7);
      $display("Test soft done");

      // Slot a: result equal to threshold is not above it.
      bus(1'b1, 8'h20, 32'h88);
      bus(1'b1, 8'h24, 32'h00);
      s0 = starts;
      bus(1'b1, 8'h1c, 32'h13);
      repeat (10) @(posedge clk);
      check(starts - s0, 0);
      repeat (60) @(posedge clk);
      check((starts - s0) >= 2, 1);
      rdchk(8'h0c, 32'h0);
      rdchk(8'h28, 32'h8);
      rdchk(8'h2c, 32'h0);
      bus(1'b1, 8'h20, 32'h87);
      bus(1'b1, 8'h24, 32'hff);
      repeat (60) @(posedge clk);
      rdchk(8'h0c, 32'h2);
      check(irq, 1'b0);
      bus(1'b1, 8'h1c, 32'h00);
      bus(1'b1, 8'h0c, 32'h2);
      $display("Test slot a done");

      // Slot b with below polarity, slot a kept off.
      bus(1'b1, 8'h30, 32'h01);
      bus(1'b1, 8'h34, 32'h01);
      bus(1'b1, 8'h1c, 32'h20);
      repeat (40) @(posedge clk);
      rdchk(8'h0c, 32'h4);
      rdchk(8'h38, 32'h1);
      rdchk(8'h3c, 32'h0);
      bus(1'b1, 8'h1c, 32'h00);
      bus(1'b1, 8'h0c, 32'h4);
      $display("Test slot b done");

      // Shutdown: clearing the flag in time cancels it, else it fires.
      bus(1'b1, 8'h1c, 32'h50);
      poll(32'h2);
      bus(1'b1, 8'h1c, 32'h40);
      bus(1'b1, 8'h0c, 32'h2);
      repeat (60) @(posedge clk);
      check(shutdown_req, 1'b0);
      bus(1'b1, 8'h1c, 32'h50);
      poll(32'h2);
      check(shutdown_req, 1'b0);
      repeat (50) @(posedge clk);
      check(shutdown_req, 1'b1);
      $display("Test shutdown done");

      // A second reset in mid-run clears the sticky request.
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      check(shutdown_req, 1'b0);
      resetn <= 1'b1;
      rdchk(8'h08, 32'h7);
      $display("Test second reset done");
      summarize();
   end
endmodule // testbench
